// [inc/motion_window_pkg.sv]
package motion_window_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Clock and timing.
   localparam int CLK_PERIOD_NS = 20;
   localparam int MS_NS = 1000000;
   localparam int CYCLES_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////
   // Register port and register addresses.
   localparam int REG_ADDR_W = 16;
   localparam int REG_DATA_W = 32;
   localparam int PARAM_W = 16;
   localparam logic [15:0] ADDR_LIMIT_ENABLE = 16'h0606;
   localparam logic [15:0] ADDR_UPPER_TRAVEL_BOUND = 16'h0608;
   localparam logic [15:0] ADDR_LOWER_TRAVEL_BOUND = 16'h060a;
   localparam logic [15:0] ADDR_POSITION_DEVIATION_BAND = 16'h0632;
   localparam logic [15:0] ADDR_SPEED_FLOOR_LEVEL = 16'h0636;
   localparam logic [15:0] ADDR_MONITOR_DWELL_TIME = 16'h063a;
   localparam logic [15:0] ADDR_REST_BAND_WIDTH = 16'h1112;
   localparam logic [15:0] ADDR_REST_DWELL_TIME = 16'h1114;
   localparam logic [15:0] ADDR_REST_TIMEOUT = 16'h1116;
   localparam logic [15:0] ADDR_MONITOR_STATUS = 16'h1118;
   localparam logic [15:0] ADDR_OPERATING_MODE_CAPS = 16'h1b28;

   ////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [31:0] RST_UPPER_TRAVEL_BOUND = 32'h7fff_ffff;
   localparam logic [31:0] RST_LOWER_TRAVEL_BOUND = 32'h8000_0000;
   localparam logic [15:0] RST_POSITION_DEVIATION_BAND = 16'h000a;
   localparam logic [15:0] RST_SPEED_FLOOR_LEVEL = 16'h000a;
   localparam logic [15:0] RST_MONITOR_DWELL_TIME = 16'h0000;
   localparam logic [15:0] RST_REST_BAND_WIDTH = 16'h000a;
   localparam logic [15:0] RST_REST_DWELL_TIME = 16'h0000;
   localparam logic [15:0] RST_REST_TIMEOUT = 16'h0000;
   localparam logic [1:0] RST_LIMIT_ENABLE = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int LIMIT_EN_POS = 0;
   localparam int LIMIT_EN_NEG = 1;
   localparam int STAT_SPEED_OK = 0;
   localparam int STAT_DEVIATION_OK = 1;
   localparam int STAT_STANDSTILL = 2;
   localparam int STAT_REST_TIMEOUT = 3;
   localparam int STAT_POS_LIMIT = 4;
   localparam int STAT_NEG_LIMIT = 5;
   localparam int STAT_TIMING = 6;

   ////////////////////////////////////////////////////////////////////////
   // Operating mode capability bits.
   localparam int CAP_PROFILE_POSITION = 0;
   localparam int CAP_PROFILE_VELOCITY = 2;
   localparam int CAP_HOMING = 5;
   localparam int CAP_JOG = 16;
   localparam int CAP_OSCILLATOR = 22;
   localparam logic [31:0] CAP_MASK = 32'h007f_0025;

   ////////////////////////////////////////////////////////////////////////
   // Standstill timeout states.
   typedef enum logic [0:0] {
      TO_IDLE = 1'b0,
      TO_TIMING = 1'b1
   } rest_timeout_state_t;

endpackage

// [design/dwell_timer.sv]
`timescale 1ns/1ps
module dwell_timer #(
   parameter int CNT_W = 16
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_tick,
   input wire logic i_enable,
   input wire logic i_in_range,
   input wire logic [CNT_W-1:0] i_limit,
   output logic o_valid
);

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic valid_next;
   wire run = i_enable && i_in_range;

   // The count saturates so a long dwell never wraps into a false result.
   assign count_next = !run ? '0 :
      (i_tick && count_reg != '1) ? count_reg + 1'b1 : count_reg;
   assign valid_next = run && (count_reg >= i_limit);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         count_reg <= '0;
         o_valid <= 1'b0;
      end else begin
         count_reg <= count_next;
         o_valid <= valid_next;
      end
   end

   chk_dwell_restart: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !run |=> (count_reg == '0) && !o_valid)
      else $error("Dwell count did not restart after leaving range.");

   chk_dwell_valid: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_valid |-> $past(run) && ($past(count_reg) >= $past(i_limit)))
      else $error("Dwell result valid before the dwell time elapsed.");

endmodule

// [design/drive_motion_window_monitor.sv]
`timescale 1ns/1ps
module drive_motion_window_monitor
   import motion_window_pkg::*;
#(
   parameter int TICK_CYCLES = motion_window_pkg::CYCLES_PER_MS,
   parameter logic signed [31:0] USER_MIN = 32'sh8000_0000,
   parameter logic signed [31:0] USER_MAX = 32'sh7fff_ffff,
   parameter logic [31:0] MODE_CAPS = 32'h007f_0025
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [motion_window_pkg::REG_ADDR_W-1:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [motion_window_pkg::REG_DATA_W-1:0] i_reg_wdata,
   output logic [motion_window_pkg::REG_DATA_W-1:0] o_reg_rdata,
   output logic o_reg_ack,
   output logic o_reg_err,
   input wire logic signed [15:0] i_actual_speed,
   input wire logic signed [31:0] i_position_deviation,
   input wire logic signed [31:0] i_actual_position,
   input wire logic i_homing_done,
   input wire logic i_target_reached,
   input wire logic i_profile_done,
   output logic o_speed_floor_ok,
   output logic o_deviation_ok,
   output logic o_standstill,
   output logic o_rest_timeout_evt,
   output logic o_pos_limit_hit,
   output logic o_neg_limit_hit
);

   ////////////////////////////////////////////////////////////////////////
   // Parameter registers.
   logic signed [31:0] upper_travel_bound_reg;
   logic signed [31:0] lower_travel_bound_reg;
   logic [PARAM_W-1:0] position_deviation_band_reg;
   logic [PARAM_W-1:0] speed_floor_level_reg;
   logic [PARAM_W-1:0] monitor_dwell_time_reg;
   logic [PARAM_W-1:0] rest_band_width_reg;
   logic [PARAM_W-1:0] rest_dwell_time_reg;
   logic [PARAM_W-1:0] rest_timeout_reg;
   logic [1:0] limit_enable_reg;
   logic timeout_flag_reg;

   wire [31:0] wdata = i_reg_wdata;
   wire wr_limit_en = i_reg_wr && i_reg_addr == ADDR_LIMIT_ENABLE;
   wire wr_upper = i_reg_wr && i_reg_addr == ADDR_UPPER_TRAVEL_BOUND;
   wire wr_lower = i_reg_wr && i_reg_addr == ADDR_LOWER_TRAVEL_BOUND;
   wire wr_pos_band = i_reg_wr && i_reg_addr == ADDR_POSITION_DEVIATION_BAND;
   wire wr_speed = i_reg_wr && i_reg_addr == ADDR_SPEED_FLOOR_LEVEL;
   wire wr_mon_dwell = i_reg_wr && i_reg_addr == ADDR_MONITOR_DWELL_TIME;
   wire wr_rest_band = i_reg_wr && i_reg_addr == ADDR_REST_BAND_WIDTH;
   wire wr_rest_dwell = i_reg_wr && i_reg_addr == ADDR_REST_DWELL_TIME;
   wire wr_rest_tout = i_reg_wr && i_reg_addr == ADDR_REST_TIMEOUT;
   wire wr_status = i_reg_wr && i_reg_addr == ADDR_MONITOR_STATUS;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         upper_travel_bound_reg <= RST_UPPER_TRAVEL_BOUND;
         lower_travel_bound_reg <= RST_LOWER_TRAVEL_BOUND;
         position_deviation_band_reg <= RST_POSITION_DEVIATION_BAND;
         speed_floor_level_reg <= RST_SPEED_FLOOR_LEVEL;
         monitor_dwell_time_reg <= RST_MONITOR_DWELL_TIME;
         rest_band_width_reg <= RST_REST_BAND_WIDTH;
         rest_dwell_time_reg <= RST_REST_DWELL_TIME;
         rest_timeout_reg <= RST_REST_TIMEOUT;
         limit_enable_reg <= RST_LIMIT_ENABLE;
      end else begin
         if (wr_limit_en) limit_enable_reg <= wdata[1:0];
         if (wr_upper) upper_travel_bound_reg <= wdata;
         if (wr_lower) lower_travel_bound_reg <= wdata;
         if (wr_pos_band) position_deviation_band_reg <= wdata[15:0];
         if (wr_speed) speed_floor_level_reg <= wdata[15:0];
         if (wr_mon_dwell) monitor_dwell_time_reg <= wdata[15:0];
         if (wr_rest_band) rest_band_width_reg <= wdata[15:0];
         if (wr_rest_dwell) rest_dwell_time_reg <= wdata[15:0];
         if (wr_rest_tout) rest_timeout_reg <= wdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Millisecond tick.
   logic [31:0] presc_reg;
   wire tick = presc_reg == 32'(TICK_CYCLES - 1);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) presc_reg <= '0;
      else presc_reg <= tick ? '0 : presc_reg + 32'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Window monitors.
   wire [32:0] speed_mag = i_actual_speed < 0 ?
      33'(-34'(i_actual_speed)) : 33'(i_actual_speed);
   wire [32:0] dev_mag = i_position_deviation < 0 ?
      33'(-34'(i_position_deviation)) : 33'(i_position_deviation);
   wire speed_in = speed_mag < 33'(speed_floor_level_reg);
   wire dev_in = dev_mag < 33'(position_deviation_band_reg);
   wire rest_in = dev_mag <= 33'(rest_band_width_reg);
   wire rest_en = rest_dwell_time_reg != '0;

   dwell_timer #(.CNT_W(PARAM_W)) u_speed_dwell (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tick(tick),
      .i_enable(1'b1), .i_in_range(speed_in),
      .i_limit(monitor_dwell_time_reg), .o_valid(o_speed_floor_ok)
   );

   dwell_timer #(.CNT_W(PARAM_W)) u_dev_dwell (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tick(tick),
      .i_enable(1'b1), .i_in_range(dev_in),
      .i_limit(monitor_dwell_time_reg), .o_valid(o_deviation_ok)
   );

   dwell_timer #(.CNT_W(PARAM_W)) u_rest_dwell (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tick(tick),
      .i_enable(rest_en), .i_in_range(rest_in),
      .i_limit(rest_dwell_time_reg), .o_valid(o_standstill)
   );

   ////////////////////////////////////////////////////////////////////////
   // Standstill timeout.
   rest_timeout_state_t to_state_reg;
   rest_timeout_state_t to_state_next;
   logic [PARAM_W-1:0] to_count_reg;
   logic [PARAM_W-1:0] to_count_next;
   logic expire;

   wire to_start = (i_target_reached || i_profile_done) &&
      rest_timeout_reg != '0 && rest_en;

   always_comb begin
      to_state_next = to_state_reg;
      to_count_next = to_count_reg;
      expire = 1'b0;
      case (to_state_reg)
         TO_IDLE: begin
            if (to_start) begin
               to_state_next = TO_TIMING;
               to_count_next = '0;
            end
         end
         TO_TIMING: begin
            if (o_standstill || rest_timeout_reg == '0 || !rest_en) begin
               to_state_next = TO_IDLE;
            end else if (tick && to_count_reg + 1'b1 >= rest_timeout_reg) begin
               expire = 1'b1;
               to_state_next = TO_IDLE;
            end else if (to_start) begin
               to_count_next = '0;
            end else if (tick) begin
               to_count_next = to_count_reg + 1'b1;
            end
         end
         default: to_state_next = TO_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         to_state_reg <= TO_IDLE;
         to_count_reg <= '0;
         o_rest_timeout_evt <= 1'b0;
         timeout_flag_reg <= 1'b0;
      end else begin
         to_state_reg <= to_state_next;
         to_count_reg <= to_count_next;
         o_rest_timeout_evt <= expire;
         if (expire) timeout_flag_reg <= 1'b1;
         else if (wr_status && wdata[STAT_REST_TIMEOUT])
            timeout_flag_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Software travel limits.
   wire signed [31:0] upper_eff = upper_travel_bound_reg > USER_MAX ?
      USER_MAX : upper_travel_bound_reg < USER_MIN ?
      USER_MIN : upper_travel_bound_reg;
   wire signed [31:0] lower_eff = lower_travel_bound_reg > USER_MAX ?
      USER_MAX : lower_travel_bound_reg < USER_MIN ?
      USER_MIN : lower_travel_bound_reg;
   wire pos_hit_next = i_homing_done && limit_enable_reg[LIMIT_EN_POS] &&
      i_actual_position > upper_eff;
   wire neg_hit_next = i_homing_done && limit_enable_reg[LIMIT_EN_NEG] &&
      i_actual_position < lower_eff;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_pos_limit_hit <= 1'b0;
         o_neg_limit_hit <= 1'b0;
      end else begin
         o_pos_limit_hit <= pos_hit_next;
         o_neg_limit_hit <= neg_hit_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register read and answer.
   logic [31:0] rd_value;
   logic rd_hit;
   wire [31:0] status_word = {25'h0, to_state_reg == TO_TIMING,
      o_neg_limit_hit, o_pos_limit_hit, timeout_flag_reg,
      o_standstill, o_deviation_ok, o_speed_floor_ok};

   always_comb begin
      rd_hit = 1'b1;
      rd_value = 32'h0;
      if (i_reg_addr == ADDR_LIMIT_ENABLE) rd_value = {30'h0, limit_enable_reg};
      else if (i_reg_addr == ADDR_UPPER_TRAVEL_BOUND)
         rd_value = upper_travel_bound_reg;
      else if (i_reg_addr == ADDR_LOWER_TRAVEL_BOUND)
         rd_value = lower_travel_bound_reg;
      else if (i_reg_addr == ADDR_POSITION_DEVIATION_BAND)
         rd_value = {16'h0, position_deviation_band_reg};
      else if (i_reg_addr == ADDR_SPEED_FLOOR_LEVEL)
         rd_value = {16'h0, speed_floor_level_reg};
      else if (i_reg_addr == ADDR_MONITOR_DWELL_TIME)
         rd_value = {16'h0, monitor_dwell_time_reg};
      else if (i_reg_addr == ADDR_REST_BAND_WIDTH)
         rd_value = {16'h0, rest_band_width_reg};
      else if (i_reg_addr == ADDR_REST_DWELL_TIME)
         rd_value = {16'h0, rest_dwell_time_reg};
      else if (i_reg_addr == ADDR_REST_TIMEOUT)
         rd_value = {16'h0, rest_timeout_reg};
      else if (i_reg_addr == ADDR_MONITOR_STATUS) rd_value = status_word;
      else if (i_reg_addr == ADDR_OPERATING_MODE_CAPS)
         rd_value = MODE_CAPS & CAP_MASK;
      else rd_hit = 1'b0;
   end

   wire wr_ro = i_reg_addr == ADDR_OPERATING_MODE_CAPS;
   wire req = i_reg_rd || i_reg_wr;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_reg_rdata <= 32'h0;
         o_reg_ack <= 1'b0;
         o_reg_err <= 1'b0;
      end else begin
         o_reg_ack <= req;
         o_reg_err <= req && (!rd_hit || (i_reg_wr && wr_ro));
         o_reg_rdata <= (i_reg_rd && rd_hit) ? rd_value : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_to_start;
      to_state_reg == TO_IDLE && to_start;
   endsequence

   chk_speed_floor: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_speed_floor_ok |-> $past(speed_in))
      else $error("Speed result valid while speed was above floor.");

   chk_dev_band: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_deviation_ok |-> $past(dev_in))
      else $error("Deviation result valid while outside the band.");

   chk_lower_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_lower |=> lower_travel_bound_reg == $past(wdata))
      else $error("Lower travel bound not stored as written.");

   chk_upper_clamp: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      upper_eff <= USER_MAX && upper_eff >= USER_MIN)
      else $error("Effective upper bound outside user range.");

   chk_rest_band: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_standstill |-> $past(rest_in) && $past(rest_en))
      else $error("Standstill declared outside rest band.");

   chk_rest_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !rest_en [*2] |-> !o_standstill)
      else $error("Standstill declared with zero rest dwell.");

   chk_tout_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rest_timeout_reg == '0 |=> !o_rest_timeout_evt)
      else $error("Timeout event with timeout disabled.");

   chk_tout_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_to_start |=> to_state_reg == TO_TIMING && to_count_reg == '0)
      else $error("Timeout timing did not start on target event.");

   chk_caps_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_reg_rd && i_reg_addr == ADDR_OPERATING_MODE_CAPS |=>
      o_reg_ack && o_reg_rdata == (MODE_CAPS & CAP_MASK))
      else $error("Capability bitmap read wrong.");

   chk_homing_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !i_homing_done |=> !o_pos_limit_hit && !o_neg_limit_hit)
      else $error("Travel limit flagged before homing done.");

   chk_tout_event: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_rest_timeout_evt |-> timeout_flag_reg && !$past(o_standstill))
      else $error("Timeout event without sticky flag.");

endmodule

// [testbench/fieldbus_master.sv]
`timescale 1ns/1ps
module fieldbus_master (
   input wire logic i_clk,
   input wire logic [31:0] i_rdata,
   input wire logic i_ack,
   input wire logic i_err,
   output logic [15:0] o_addr,
   output logic o_wr,
   output logic o_rd,
   output logic [31:0] o_wdata
);
   initial begin
      o_addr = 16'hffff;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 32'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   // One strobe pulse per access, then a bounded wait for the answer.
   task automatic access(input logic wr, input logic [15:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e,
         output logic ok);
      int k;
      k = 0;
      @(posedge i_clk);
      #1;
      o_addr = a;
      o_wdata = d;
      o_wr = wr;
      o_rd = ~wr;
      @(posedge i_clk);
      #1;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
      while (i_ack !== 1'b1 && k < 4) begin
         @(posedge i_clk);
         #1;
         k++;
      end
      ok = (i_ack === 1'b1);
      q = i_rdata;
      e = i_err;
   endtask
endmodule

// [testbench/drive_motion_window_monitor_tb.sv]
`timescale 1ns/1ps
module drive_motion_window_monitor_tb;
   import motion_window_pkg::*;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [15:0] addr;
   logic wr, rd, ack, err;
   logic [31:0] wdata, rdata;
   logic signed [15:0] speed = 16'sd500;
   logic signed [31:0] dev = 32'sd500;
   logic signed [31:0] pos = 32'sd0;
   logic homed = 1'b0;
   logic target = 1'b0;
   logic prof = 1'b0;
   wire [5:0] flags;
   int miscompares = 0;
   int num_checks = 0;

   always #10 i_clk = ~i_clk;

   fieldbus_master u_master (.i_clk(i_clk), .i_rdata(rdata), .i_ack(ack),
      .i_err(err), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

   drive_motion_window_monitor #(.TICK_CYCLES(10), .USER_MIN(-32'sd1000),
         .USER_MAX(32'sd1000)) u_dut (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .o_reg_ack(ack), .o_reg_err(err),
      .i_actual_speed(speed), .i_position_deviation(dev),
      .i_actual_position(pos), .i_homing_done(homed),
      .i_target_reached(target), .i_profile_done(prof),
      .o_speed_floor_ok(flags[0]), .o_deviation_ok(flags[1]),
      .o_standstill(flags[2]), .o_rest_timeout_evt(flags[3]),
      .o_pos_limit_hit(flags[4]), .o_neg_limit_hit(flags[5]));

   ////////////////////////////////////////////////////////////////////////
   // Shared checking and access tasks.
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp,
         input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         miscompares++;
      end
   endtask

   task automatic access(input logic w, input logic [15:0] a,
         input logic [31:0] d, input logic [31:0] exp, input logic [31:0] m,
         input logic exp_err);
      logic [31:0] q;
      logic e, ok;
      u_master.access(w, a, d, q, e, ok);
      if (ok !== 1'b1) begin
         $display("mismatch ack at %h expected 1 seen 0", a);
         miscompares++;
         conclude();
      end
      if (!w) check("rdata", exp & m, q & m);
      check("err", {31'h0, exp_err}, {31'h0, e});
   endtask

   task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
      access(1'b1, a, d, 32'h0, 32'h0, 1'b0);
   endtask

   task automatic wait_flag(input int idx, input logic v, input int n);
      int k;
      k = 0;
      while (flags[idx] !== v && k < n) begin
         @(posedge i_clk);
         #1;
         k++;
      end
      num_checks++;
      if (flags[idx] !== v) begin
         $display("mismatch flag %0d expected %b seen %b", idx, v, flags[idx]);
         miscompares++;
         conclude();
      end
   endtask

   task automatic hold_flag(input int idx, input logic v, input int n);
      int bad;
      bad = 0;
      repeat (n) begin
         @(posedge i_clk);
         #1;
         if (flags[idx] !== v) bad++;
      end
      check("flag steady", 32'h0, 32'(bad));
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Test sequence.
   initial begin
      repeat (20) @(posedge i_clk);
      #1;
      i_sys_rst = 1'b0;
      // Reset values, read-only map and unmapped places.
      access(1'b0, ADDR_UPPER_TRAVEL_BOUND, 0, 32'h7fffffff, '1, 0);
      access(1'b0, ADDR_LOWER_TRAVEL_BOUND, 0, 32'h80000000, '1, 0);
      access(1'b0, ADDR_SPEED_FLOOR_LEVEL, 0, 32'h0000000a, '1, 0);
      access(1'b0, ADDR_POSITION_DEVIATION_BAND, 0, 32'ha, '1, 0);
      access(1'b0, ADDR_MONITOR_DWELL_TIME, 0, 32'h0, '1, 0);
      access(1'b0, ADDR_REST_BAND_WIDTH, 0, 32'h0000000a, '1, 0);
      access(1'b0, ADDR_REST_DWELL_TIME, 0, 32'h0, '1, 0);
      access(1'b0, ADDR_REST_TIMEOUT, 0, 32'h0, '1, 0);
      access(1'b0, ADDR_OPERATING_MODE_CAPS, 0, 32'h007f0025, '1, 0);
      access(1'b1, ADDR_OPERATING_MODE_CAPS, 32'h1, 0, 0, 1'b1);
      access(1'b0, ADDR_OPERATING_MODE_CAPS, 0, 32'h007f0025, '1, 0);
      access(1'b0, 16'h0700, 0, 32'h0, '1, 1'b1);
      access(1'b1, 16'h0700, 32'h5, 0, 0, 1'b1);
      $display("test registers done");
      // Speed floor with a two millisecond dwell and a glitch.
      reg_wr(ADDR_MONITOR_DWELL_TIME, 32'h2);
      reg_wr(ADDR_SPEED_FLOOR_LEVEL, 32'h5);
      speed = 16'sd3;
      hold_flag(0, 1'b0, 9);
      wait_flag(0, 1'b1, 25);
      speed = 16'sd8;
      wait_flag(0, 1'b0, 2);
      speed = -16'sd3;
      hold_flag(0, 1'b0, 9);
      wait_flag(0, 1'b1, 25);
      $display("test speed floor done");
      // Position deviation against the default band.
      dev = 32'sd5;
      hold_flag(1, 1'b0, 9);
      wait_flag(1, 1'b1, 25);
      dev = -32'sd12;
      wait_flag(1, 1'b0, 2);
      dev = -32'sd9;
      wait_flag(1, 1'b1, 25);
      $display("test deviation done");
      // Standstill window, off and on, at the band edge.
      hold_flag(2, 1'b0, 30);
      reg_wr(ADDR_REST_DWELL_TIME, 32'h1);
      wait_flag(2, 1'b1, 25);
      dev = 32'sd11;
      wait_flag(2, 1'b0, 2);
      dev = 32'sd10;
      wait_flag(2, 1'b1, 25);
      dev = 32'sd500;
      $display("test standstill done");
      // Standstill timeout from both start events.
      reg_wr(ADDR_REST_TIMEOUT, 32'h2);
      for (int k = 0; k < 3; k++) begin
         if (k == 2) reg_wr(ADDR_REST_TIMEOUT, 32'h0);
         target = (k != 1);
         prof = (k == 1);
         @(posedge i_clk);
         #1;
         target = 1'b0;
         prof = 1'b0;
         if (k == 2) begin
            hold_flag(3, 1'b0, 40);
         end else begin
            hold_flag(3, 1'b0, 9);
            wait_flag(3, 1'b1, 25);
            hold_flag(3, 1'b0, 1);
            access(1'b0, ADDR_MONITOR_STATUS, 0, 32'h8, 32'h8, 0);
            reg_wr(ADDR_MONITOR_STATUS, 32'h8);
            access(1'b0, ADDR_MONITOR_STATUS, 0, 32'h0, 32'h8, 0);
         end
      end
      // Clearing the timeout while timing ends timing without an event.
      reg_wr(ADDR_REST_TIMEOUT, 32'h2);
      target = 1'b1;
      @(posedge i_clk);
      #1;
      target = 1'b0;
      access(1'b0, ADDR_MONITOR_STATUS, 0, 32'h40, 32'h40, 0);
      reg_wr(ADDR_REST_TIMEOUT, 32'h0);
      access(1'b0, ADDR_MONITOR_STATUS, 0, 32'h0, 32'h40, 0);
      hold_flag(3, 1'b0, 40);
      $display("test rest timeout done");
      // Travel limits, homing gate and clamping.
      reg_wr(ADDR_LIMIT_ENABLE, 32'h3);
      reg_wr(ADDR_UPPER_TRAVEL_BOUND, 32'd100);
      reg_wr(ADDR_LOWER_TRAVEL_BOUND, 32'hffffff9c);
      pos = 32'sd200;
      hold_flag(4, 1'b0, 5);
      homed = 1'b1;
      wait_flag(4, 1'b1, 3);
      pos = -32'sd200;
      wait_flag(5, 1'b1, 3);
      hold_flag(4, 1'b0, 1);
      reg_wr(ADDR_UPPER_TRAVEL_BOUND, 32'h1388);
      access(1'b0, ADDR_UPPER_TRAVEL_BOUND, 0, 32'h1388, '1, 0);
      pos = 32'sd2000;
      wait_flag(4, 1'b1, 3);
      reg_wr(ADDR_LOWER_TRAVEL_BOUND, 32'h80000000);
      access(1'b0, ADDR_LOWER_TRAVEL_BOUND, 0, 32'h80000000, '1, 0);
      pos = -32'sd2000;
      wait_flag(5, 1'b1, 3);
      pos = -32'sd500;
      wait_flag(5, 1'b0, 3);
      $display("test travel limits done");
      conclude();
   end
endmodule
